//--- pkg/modem_params.svh
`ifndef MODEM_PARAMS_SVH
`define MODEM_PARAMS_SVH
// Notes on behaviour
// R1 - mask register enables alert per source.
// R2 - status clear command clears sticky flags, releasing alert; flags otherwise stay.
// R3 - loop loss monitoring off after reset, on only with its mask bit.
// R4 - low loop current sets loop loss flag.
// R5 - with result enable, send I on loss, L on recovery.
// R6 - carrier loss in data mode alerts when pin four is alert and mask set.
// R7 - pin two shows carrier detect when function 01 and pin enable set.
// R8 - v23 enabled for modulation format xx10xx00 or xx01xx00.
// R9 - reverse bit: transmit 75 bps, receive on fast channel.
// R10 - forward bit: receive 75 bps, transmit on fast channel.
// R11 - fast select bit picks 1200 bps, else 600 bps.
// R12 - connect sends c when transmitting fast, v when transmitting 75.
// R13 - turnaround command accepted only as master.
// R14 - host escapes to command mode before sending turnaround command.
// R15 - master: tone 1300 Hz, 440 ms window, over 40 ms of 390 gives c, else hang up N.
// R16 - slave turnaround starts after received carrier drop over 20 ms.
// R17 - slave: tone 390 Hz, 400 ms window for 1300 Hz; pass sets flag, v.
// R18 - first slave check failing: reverse again, look for 390 Hz; pass sets flag, c.
// R19 - second slave check failing: hang up, set flag, send N.
// R20 - successful turnaround updates forward and reverse bits; the code leaves them unchanged after a pass in the second slave check.
// R21 - pin four function 11 makes it the host alert.
// R22 - ninth bit enabled with function bit clear mirrors the alert output.
// R23 - alert held low while any enabled flag is set.
`define CLK_HZ 20000000
`define MS_DIV 1000
`define CYC_PER_MS (`CLK_HZ / `MS_DIV)
`define T_MASTER_WIN_MS 440
`define T_SLAVE_WIN1_MS 400
`define T_SLAVE_WIN2_MS 440
`define T_TONE_MIN_MS 40
`define T_DROP_MIN_MS 20
`define OFS_MASK 5'h00
`define OFS_STATUS 5'h04
`define OFS_MODFMT 5'h08
`define OFS_PINCFG 5'h0c
`define OFS_MISC 5'h10
`define OFS_CMD 5'h14
`define OFS_STATE 5'h18
`define RST_MASK 8'h00
`define RST_MODFMT 8'h00
`define RST_PINCFG 8'h00
`define RST_MISC 8'h00
`define BIT_TURN 7
`define BIT_CD_MASK 7
`define BIT_LOOP 4
`define BIT_PAR 3
`define BIT_RING 2
`define BIT_OVER 1
`define BIT_WAKE 6
`define BIT_CDLOST 0
`define MF_REV 5
`define MF_FWD 4
`define MF_FAST 2
`define PIN4_ALERT 2'h3
`define PIN2_CD 2'h1
`define MISC_CPE 7
`define MISC_NBF 3
`define MISC_LRE 1
`define MISC_NBE 0
`define CMD_TURN 0
`define CH_C 8'h63
`define CH_V 8'h76
`define CH_N 8'h4e
`define CH_I 8'h49
`define CH_L 8'h4c
`endif

//--- pkg/modem_pkg.sv
package modem_pkg;
  typedef logic [23:0] cnt_t;
  typedef enum logic [1:0] {st_idle, st_master_win, st_slave_win1, st_slave_win2} v23_state_t;
  typedef struct packed {
    cnt_t win;
    cnt_t tone;
    logic busy;
    logic done;
    logic pass;
  } window_state_t;
  typedef struct packed {
    cnt_t low;
    logic fired;
    logic drop;
  } drop_state_t;
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] modfmt;
    logic [7:0] pincfg;
    logic [7:0] misc;
    logic [7:0] flags;
    v23_state_t fsm;
    logic win_start;
    cnt_t win_len;
    logic tx_high;
    logic hangup;
    logic [7:0] result_char;
    logic result_valid;
    logic alert_n;
    logic pin4_n;
    logic pin2_cd;
    logic ninth;
    logic v23_en;
    logic tx_slow;
    logic rx_slow;
    logic fast;
    logic waitreq;
    logic [31:0] readdata;
    logic carrier_d;
    logic loop_d;
  } core_state_t;
endpackage

//--- hdl/carrier_window.sv
`timescale 1ns/100ps
module carrier_window
  import modem_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic i_start,
  input wire cnt_t i_window_cycles,
  input wire cnt_t i_min_cycles,
  input wire logic i_tone,
  output logic o_done,
  output logic o_pass
);
  window_state_t s;
  window_state_t n;

  // count tone cycles over a fixed window, judge at its end
  always_comb begin
    n = s;
    n.done = 1'b0;
    if (i_start) begin
      n.win = i_window_cycles;
      n.tone = '0;
      n.busy = 1'b1;
    end else if (s.busy) begin
      n.win = s.win - 24'h1;
      if (i_tone && s.tone != '1) begin
        n.tone = s.tone + 24'h1;
      end
      if (s.win == 24'h1) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.pass = n.tone > i_min_cycles; // more than, not equal
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      s <= '0;
    end else if (i_enable) begin
      s <= n;
    end
  end

  assign o_done = s.done;
  assign o_pass = s.pass;
endmodule

//--- hdl/carrier_drop_filter.sv
`timescale 1ns/100ps
module carrier_drop_filter
  import modem_pkg::*;
#(
  parameter cnt_t DROP_CYCLES = 24'h1
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic i_arm,
  input wire logic i_carrier,
  output logic o_drop
);
  drop_state_t s;
  drop_state_t n;

  // one pulse once carrier has been absent longer than the limit
  always_comb begin
    n = s;
    n.drop = 1'b0;
    if (!i_arm || i_carrier) begin
      n.low = '0;
      n.fired = 1'b0;
    end else if (!s.fired) begin
      n.low = s.low + 24'h1;
      if (s.low == DROP_CYCLES) begin
        n.drop = 1'b1; // R16
        n.fired = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      s <= '0;
    end else if (i_enable) begin
      s <= n;
    end
  end

  assign o_drop = s.drop;
endmodule

//--- hdl/modem_alert_v23.sv
`timescale 1ns/100ps
`include "modem_params.svh"
module modem_alert_v23
  import modem_pkg::*;
#(
  parameter cnt_t MASTER_WIN_CYCLES = cnt_t'(`T_MASTER_WIN_MS * `CYC_PER_MS),
  parameter cnt_t SLAVE_WIN1_CYCLES = cnt_t'(`T_SLAVE_WIN1_MS * `CYC_PER_MS),
  parameter cnt_t SLAVE_WIN2_CYCLES = cnt_t'(`T_SLAVE_WIN2_MS * `CYC_PER_MS),
  parameter cnt_t TONE_MIN_CYCLES = cnt_t'(`T_TONE_MIN_MS * `CYC_PER_MS),
  parameter cnt_t DROP_MIN_CYCLES = cnt_t'(`T_DROP_MIN_MS * `CYC_PER_MS)
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic o_waitrequest,
  output logic [31:0] o_readdata,
  input wire logic i_data_mode,
  input wire logic i_carrier,
  input wire logic i_tone_390,
  input wire logic i_tone_1300,
  input wire logic i_v23_connect,
  input wire logic i_loop_low,
  input wire logic i_parallel_phone,
  input wire logic i_ring,
  input wire logic i_overcurrent,
  input wire logic i_wake,
  output logic o_alert_n,
  output logic o_pin4_alert_n,
  output logic o_pin2_cd,
  output logic o_ninth_bit,
  output logic o_v23_enable,
  output logic o_tx_slow,
  output logic o_rx_slow,
  output logic o_fast_1200,
  output logic o_tx_high_tone,
  output logic o_hangup,
  output logic [7:0] o_result_char,
  output logic o_result_valid
);
  core_state_t s;
  core_state_t n;
  logic win_done;
  logic win_pass;
  logic win_tone;
  logic drop;
  logic slave_idle;

  // v23 format decode
  function automatic logic v23_mode(input logic [7:0] mf);
    v23_mode = (mf[1:0] == 2'h0) && (mf[5:4] == 2'h2 || mf[5:4] == 2'h1); // R8
  endfunction

  // pin four carries the host alert
  function automatic logic pin4_is_alert(input logic [7:0] pc);
    pin4_is_alert = pc[7:6] == `PIN4_ALERT; // R21
  endfunction

  // register read mux
  function automatic logic [31:0] read_mux(input logic [4:0] a, input core_state_t c);
    read_mux = 32'h0;
    unique case (a)
      `OFS_MASK: read_mux = {24'h0, c.mask};
      `OFS_STATUS: read_mux = {24'h0, c.flags};
      `OFS_MODFMT: read_mux = {24'h0, c.modfmt};
      `OFS_PINCFG: read_mux = {24'h0, c.pincfg};
      `OFS_MISC: read_mux = {24'h0, c.misc};
      `OFS_STATE: read_mux = {29'h0, c.tx_high, c.fsm};
      default: read_mux = 32'h0;
    endcase
  endfunction

  // tone watched depends on which check runs
  assign win_tone = (s.fsm == st_slave_win1) ? i_tone_1300 : i_tone_390;

  // slave waiting in data mode for a far-end carrier drop
  assign slave_idle = (s.fsm == st_idle) && v23_mode(s.modfmt) && s.modfmt[`MF_FWD] && i_data_mode;

  carrier_window u_window (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_enable(i_enable),
    .i_start(s.win_start),
    .i_window_cycles(s.win_len),
    .i_min_cycles(TONE_MIN_CYCLES),
    .i_tone(win_tone),
    .o_done(win_done),
    .o_pass(win_pass)
  );

  carrier_drop_filter #(
    .DROP_CYCLES(DROP_MIN_CYCLES)
  ) u_drop (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_enable(i_enable),
    .i_arm(slave_idle),
    .i_carrier(i_carrier),
    .o_drop(drop)
  );

  // next state of the whole block
  always_comb begin
    n = s;
    n.win_start = 1'b0;
    n.hangup = 1'b0;
    n.result_valid = 1'b0;
    n.carrier_d = i_carrier;
    n.loop_d = i_loop_low;

    // avalon slave: answer one cycle after the request is seen
    if (!s.waitreq) begin
      n.waitreq = 1'b1;
      if (i_write && i_byteenable[0]) begin
        unique case (i_address)
          `OFS_MASK: n.mask = i_writedata[7:0]; // R1
          `OFS_STATUS: n.flags = 8'h00; // R2
          `OFS_MODFMT: n.modfmt = i_writedata[7:0];
          `OFS_PINCFG: n.pincfg = i_writedata[7:0];
          `OFS_MISC: n.misc = i_writedata[7:0];
          `OFS_CMD: begin
            // master only, host has left data mode
            if (i_writedata[`CMD_TURN] && s.fsm == st_idle && v23_mode(s.modfmt)
                && s.modfmt[`MF_REV] && !i_data_mode) begin // R13 R14
              n.fsm = st_master_win;
              n.tx_high = 1'b1; // R15
              n.win_start = 1'b1;
              n.win_len = MASTER_WIN_CYCLES;
            end
          end
          default: ;
        endcase
      end
    end else if (i_read || i_write) begin
      n.waitreq = 1'b0;
      n.readdata = read_mux(i_address, s);
    end

    // sticky event flags, set after the clear so a set wins
    if (i_loop_low && s.mask[`BIT_LOOP]) begin
      n.flags[`BIT_LOOP] = 1'b1; // R3 R4
    end
    if (i_parallel_phone) begin
      n.flags[`BIT_PAR] = 1'b1;
    end
    if (i_ring) begin
      n.flags[`BIT_RING] = 1'b1;
    end
    if (i_overcurrent) begin
      n.flags[`BIT_OVER] = 1'b1;
    end
    if (i_wake) begin
      n.flags[`BIT_WAKE] = 1'b1;
    end
    if (s.carrier_d && !i_carrier && i_data_mode && s.mask[`BIT_CD_MASK] && pin4_is_alert(s.pincfg)) begin
      n.flags[`BIT_CDLOST] = 1'b1; // R6
    end

    // loop current result characters
    if (s.mask[`BIT_LOOP] && s.misc[`MISC_LRE] && (i_loop_low != s.loop_d)) begin
      n.result_valid = 1'b1;
      n.result_char = i_loop_low ? `CH_I : `CH_L; // R5
    end

    // connect result character
    if (i_v23_connect && v23_mode(s.modfmt)) begin
      n.result_valid = 1'b1;
      n.result_char = s.modfmt[`MF_FWD] ? `CH_C : `CH_V; // R12
    end

    // turnaround sequences
    unique case (s.fsm)
      st_idle: begin
        // a turnaround command taken this cycle keeps its high tone
        if (n.fsm == st_idle) begin
          n.tx_high = s.modfmt[`MF_FWD]; // R9 R10
        end
        if (drop) begin
          n.fsm = st_slave_win1; // R16
          n.tx_high = 1'b0; // R17
          n.win_start = 1'b1;
          n.win_len = SLAVE_WIN1_CYCLES;
        end
      end
      st_master_win: begin
        if (win_done) begin
          n.fsm = st_idle;
          n.result_valid = 1'b1;
          if (win_pass) begin
            n.result_char = `CH_C; // R15
            n.modfmt[`MF_REV] = 1'b0; // R20
            n.modfmt[`MF_FWD] = 1'b1; // R20
          end else begin
            n.result_char = `CH_N; // R15
            n.hangup = 1'b1;
          end
        end
      end
      st_slave_win1: begin
        if (win_done) begin
          if (win_pass) begin
            n.fsm = st_idle;
            n.flags[`BIT_TURN] = 1'b1; // R17
            n.result_valid = 1'b1;
            n.result_char = `CH_V; // R17
            n.modfmt[`MF_REV] = 1'b1; // R20
            n.modfmt[`MF_FWD] = 1'b0; // R20
          end else begin
            n.fsm = st_slave_win2; // R18
            n.tx_high = 1'b1;
            n.win_start = 1'b1;
            n.win_len = SLAVE_WIN2_CYCLES;
          end
        end
      end
      st_slave_win2: begin
        if (win_done) begin
          n.fsm = st_idle;
          n.flags[`BIT_TURN] = 1'b1; // R18 R19
          n.result_valid = 1'b1;
          if (win_pass) begin
            n.result_char = `CH_C; // R18
          end else begin
            n.result_char = `CH_N; // R19
            n.hangup = 1'b1;
          end
        end
      end
    endcase

    // alert pins follow flags gated by their enables
    n.alert_n = ~|(n.flags & {pin4_is_alert(n.pincfg), n.mask[6:1], 1'b1}); // R1 R23
    n.pin4_n = pin4_is_alert(n.pincfg) ? n.alert_n : 1'b1; // R21
    n.ninth = (n.misc[`MISC_NBE] && !n.misc[`MISC_NBF]) ? n.alert_n : 1'b0; // R22
    n.pin2_cd = (n.pincfg[3:2] == `PIN2_CD) && n.misc[`MISC_CPE] && i_carrier; // R7

    // rate selection
    n.v23_en = v23_mode(n.modfmt); // R8
    n.tx_slow = n.v23_en && n.modfmt[`MF_REV]; // R9
    n.rx_slow = n.v23_en && n.modfmt[`MF_FWD]; // R10
    n.fast = n.modfmt[`MF_FAST]; // R11
  end

  // state register with clock enable
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      s <= '0;
      s.mask <= `RST_MASK; // R3
      s.modfmt <= `RST_MODFMT;
      s.pincfg <= `RST_PINCFG;
      s.misc <= `RST_MISC;
      s.fsm <= st_idle;
      s.alert_n <= 1'b1;
      s.pin4_n <= 1'b1;
      s.waitreq <= 1'b1;
    end else if (i_enable) begin
      s <= n;
    end
  end

  // outputs straight from state
  assign o_waitrequest = s.waitreq;
  assign o_readdata = s.readdata;
  assign o_alert_n = s.alert_n;
  assign o_pin4_alert_n = s.pin4_n;
  assign o_pin2_cd = s.pin2_cd;
  assign o_ninth_bit = s.ninth;
  assign o_v23_enable = s.v23_en;
  assign o_tx_slow = s.tx_slow;
  assign o_rx_slow = s.rx_slow;
  assign o_fast_1200 = s.fast;
  assign o_tx_high_tone = s.tx_high;
  assign o_hangup = s.hangup;
  assign o_result_char = s.result_char;
  assign o_result_valid = s.result_valid;
endmodule

//--- dv/line_partner.sv
`timescale 1ns/100ps
module line_partner (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_tx_high,
  input wire logic [1:0] i_mode,
  output logic o_tone_390,
  output logic o_tone_1300
);
  // far modem answers with the other tone; mode 0 silent, 1 both tones, 2 low tone only
  always_ff @(posedge i_clock) begin
    o_tone_390 <= i_nrst && i_mode != 2'h0 && i_tx_high;
    o_tone_1300 <= i_nrst && i_mode == 2'h1 && !i_tx_high;
  end
endmodule

//--- dv/modem_alert_v23_sva.sv
`timescale 1ns/100ps
`include "modem_params.svh"
module modem_alert_v23_sva (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic i_carrier,
  input wire logic o_waitrequest,
  input wire logic o_alert_n,
  input wire logic o_pin4_alert_n,
  input wire logic o_pin2_cd,
  input wire logic o_tx_slow,
  input wire logic o_rx_slow,
  input wire logic o_hangup,
  input wire logic [7:0] o_result_char,
  input wire logic o_result_valid
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // bus answer shape and result pulses
  chk_wait_one: assert property (!o_waitrequest |=> o_waitrequest) else $error("answer too long");
  chk_idle_wait: assert property (o_waitrequest && !i_read && !i_write |=> o_waitrequest) else $error("answer unasked");
  chk_result_pulse: assert property (o_result_valid |=> !o_result_valid) else $error("char pulse too long");
  chk_hang_char: assert property (o_hangup |-> ##[0:1] (o_result_valid && o_result_char == `CH_N))
    else $error("hangup without no carrier char");
  // alert pins, carrier pin and rate pair
  chk_pin4_alert: assert property (!o_pin4_alert_n |-> !o_alert_n) else $error("pin four alert alone");
  chk_alert_sticky: assert property (!o_alert_n && !i_write |=> !o_alert_n) else $error("alert dropped");
  chk_cd_pin: assert property (o_pin2_cd |-> $past(i_carrier)) else $error("carrier pin without carrier");
  chk_rate_pair: assert property (!(o_tx_slow && o_rx_slow)) else $error("both directions slow");
  cover property (o_hangup);
  cover property (o_result_valid && o_result_char == `CH_V);
  cover property (!o_pin4_alert_n);
endmodule
bind modem_alert_v23 modem_alert_v23_sva u_sva (.i_clock(i_clock), .i_nrst(i_nrst), .i_write(i_write),
  .i_read(i_read), .i_carrier(i_carrier), .o_waitrequest(o_waitrequest), .o_alert_n(o_alert_n),
  .o_pin4_alert_n(o_pin4_alert_n), .o_pin2_cd(o_pin2_cd), .o_tx_slow(o_tx_slow), .o_rx_slow(o_rx_slow),
  .o_hangup(o_hangup), .o_result_char(o_result_char), .o_result_valid(o_result_valid));

//--- dv/modem_interrupt_and_v23_turnaround_bench.sv
`timescale 1ns/100ps
`include "modem_params.svh"
module modem_interrupt_and_v23_turnaround_bench;
  import modem_pkg::*;
  typedef struct packed {logic [7:0] mf; logic [7:0] exp;} row_t;
  row_t rows [5] = '{'{8'h20, 8'h0c}, '{8'h14, 8'h0b}, '{8'h24, 8'h0d}, '{8'h10, 8'h0a}, '{8'h00, 8'h00}};
  int src [4] = '{1, 2, 3, 6};
  logic [1:0] pm [3] = '{2'h1, 2'h2, 2'h0};
  logic [7:0] sc [3] = '{`CH_V, `CH_C, `CH_N};
  logic i_clock = 0, i_nrst = 0, rd = 0, wr = 0, dmode = 0, carrier = 1, connect = 0, hung = 0;
  logic [4:0] addr = 5'h00;
  logic [7:0] q, last_char = 8'h00, ev = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic en = 1;
  logic [1:0] pmode = 2'h0;
  logic t390, t1300, waitreq, alert_n, pin4_n, pin2, ninth, v23, txs, rxs, fast, txh, hang, rv;
  logic [31:0] rdata;
  logic [7:0] rchar;
  int n_mismatch = 0, total_checks = 0, cycles = 0, n_char = 0, n0, b;
  modem_alert_v23 #(.MASTER_WIN_CYCLES(24'h28), .SLAVE_WIN1_CYCLES(24'h24), .SLAVE_WIN2_CYCLES(24'h28),
    .TONE_MIN_CYCLES(24'h4), .DROP_MIN_CYCLES(24'h2)) DUT (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_enable(en), .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
    .i_byteenable(be), .o_waitrequest(waitreq), .o_readdata(rdata), .i_data_mode(dmode),
    .i_carrier(carrier), .i_tone_390(t390), .i_tone_1300(t1300), .i_v23_connect(connect),
    .i_loop_low(ev[4]), .i_parallel_phone(ev[3]), .i_ring(ev[2]), .i_overcurrent(ev[1]), .i_wake(ev[6]),
    .o_alert_n(alert_n), .o_pin4_alert_n(pin4_n), .o_pin2_cd(pin2), .o_ninth_bit(ninth), .o_v23_enable(v23),
    .o_tx_slow(txs), .o_rx_slow(rxs), .o_fast_1200(fast), .o_tx_high_tone(txh), .o_hangup(hang),
    .o_result_char(rchar), .o_result_valid(rv));
  line_partner partner (.i_clock(i_clock), .i_nrst(i_nrst), .i_tx_high(txh), .i_mode(pmode),
    .o_tone_390(t390), .o_tone_1300(t1300));
  initial forever #25 i_clock = ~i_clock;
  // result capture and hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (rv === 1'b1) begin
      last_char <= rchar;
      n_char <= n_char + 1;
    end
    if (hang === 1'b1) hung <= 1;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  task wrap_up;
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= {24'h5a5a5a, d}; // upper lanes ignored
    wr <= w;
    rd <= !w;
    @(posedge i_clock);
    while (waitreq !== 1'b0) @(posedge i_clock);
    q = rdata[7:0];
    wr <= 0;
    rd <= 0;
  endtask
  task settle;
    repeat (3) @(posedge i_clock);
  endtask
  task wait_char;
    repeat (300) if (n_char == n0) @(posedge i_clock);
  endtask
  task conn(input logic [7:0] mf, input logic [7:0] ch);
    xfer(1, `OFS_MODFMT, mf);
    n0 = n_char;
    connect <= 1;
    @(posedge i_clock);
    connect <= 0;
    wait_char;
    chk("connect char", ch, last_char);
  endtask
  initial begin
    repeat (10) @(posedge i_clock);
    i_nrst <= 1;
    chk("alert reset", 1, alert_n);
    xfer(0, `OFS_MASK, 0);
    chk("mask reset", `RST_MASK, q);
    xfer(0, 5'h1c, 0);
    chk("unmapped", 0, q);
    // write with lane 0 off is answered but ignored
    be <= 4'he;
    xfer(1, `OFS_MASK, 8'hff);
    be <= 4'hf;
    xfer(0, `OFS_MASK, 0);
    chk("lane0 off", `RST_MASK, q);
    // clock enable low freezes the flags
    en <= 0;
    ev[2] <= 1;
    settle;
    en <= 1;
    ev[2] <= 0;
    xfer(0, `OFS_STATUS, 0);
    chk("frozen flag", 0, q);
    foreach (rows[i]) begin
      xfer(1, `OFS_MODFMT, rows[i].mf);
      settle;
      chk("rates", rows[i].exp, {4'h0, v23, txs, rxs, fast});
    end
    // each of sources 1, 2, 3 and 6 flags even when masked off; the mask gates the alert
    foreach (src[i]) begin
      b = src[i];
      ev[b] <= 1;
      settle;
      ev[b] <= 0;
      settle;
      chk("unmasked alert", 1, alert_n);
      xfer(0, `OFS_STATUS, 0);
      chk("flag", 8'h01 << b, q);
      xfer(1, `OFS_MASK, 8'h01 << b);
      settle;
      chk("masked alert", 0, alert_n);
      xfer(1, `OFS_STATUS, 0);
      settle;
      chk("cleared alert", 1, alert_n);
    end
    // loop current loss off until its mask is set
    ev[4] <= 1;
    settle;
    xfer(0, `OFS_STATUS, 0);
    chk("loop off", 0, q[4]);
    ev[4] <= 0;
    xfer(1, `OFS_MISC, 8'h02);
    xfer(1, `OFS_MASK, 8'h10);
    n0 = n_char;
    ev[4] <= 1;
    wait_char;
    chk("loss char", `CH_I, last_char);
    settle;
    chk("loop alert", 0, alert_n);
    xfer(0, `OFS_STATUS, 0);
    chk("loop flag", 1, q[4]);
    n0 = n_char;
    ev[4] <= 0;
    wait_char;
    chk("return char", `CH_L, last_char);
    chk("sticky alert", 0, alert_n);
    xfer(1, `OFS_STATUS, 0);
    // ninth bit, pin four, pin two
    xfer(1, `OFS_MISC, 8'h81);
    xfer(1, `OFS_PINCFG, 8'hc4);
    settle;
    chk("ninth idle", 1, ninth);
    carrier <= 0;
    settle;
    chk("pin2 low", 0, pin2);
    carrier <= 1;
    settle;
    chk("pin2 high", 1, pin2);
    xfer(1, `OFS_MASK, 8'h08);
    ev[3] <= 1;
    settle;
    ev[3] <= 0;
    chk("pin4 alert", 0, pin4_n);
    chk("ninth alert", 0, ninth);
    xfer(1, `OFS_STATUS, 0);
    xfer(1, `OFS_MISC, 8'h89);
    settle;
    chk("ninth other use", 0, ninth);
    // carrier loss in data mode
    xfer(1, `OFS_MASK, 8'h80);
    dmode <= 1;
    carrier <= 0;
    settle;
    carrier <= 1;
    settle;
    chk("carrier loss alert", 0, alert_n);
    dmode <= 0;
    xfer(1, `OFS_MASK, 8'h00);
    xfer(1, `OFS_STATUS, 0);
    conn(8'h14, `CH_C);
    conn(8'h20, `CH_V);
    // turnaround refused while slave
    xfer(1, `OFS_MODFMT, 8'h10);
    n0 = n_char;
    xfer(1, `OFS_CMD, 8'h01);
    settle;
    chk("refused tone", 1, txh);
    chk("refused char", n0[7:0], n_char[7:0]);
    // master turnaround from command mode, answered then silent
    xfer(1, `OFS_MODFMT, 8'h20);
    pmode <= 2'h1;
    n0 = n_char;
    xfer(1, `OFS_CMD, 8'h01);
    settle;
    chk("master tone", 1, txh);
    wait_char;
    chk("master char", `CH_C, last_char);
    xfer(0, `OFS_MODFMT, 0);
    chk("swapped bits", 8'h01, {6'h0, q[5:4]});
    xfer(1, `OFS_MODFMT, 8'h20);
    pmode <= 2'h0;
    hung <= 0;
    n0 = n_char;
    xfer(1, `OFS_CMD, 8'h01);
    wait_char;
    chk("master fail char", `CH_N, last_char);
    chk("master hangup", 1, hung);
    // slave turnaround: first window, second window, failure
    for (int m = 0; m < 3; m++) begin
      xfer(1, `OFS_MODFMT, 8'h10);
      pmode <= pm[m];
      dmode <= 1;
      settle;
      n0 = n_char;
      carrier <= 0;
      wait_char;
      carrier <= 1;
      dmode <= 0;
      chk("slave char", sc[m], last_char);
      xfer(0, `OFS_STATUS, 0);
      chk("turn flag", 1, q[7]);
      xfer(1, `OFS_STATUS, 0);
    end
    wrap_up;
  end
endmodule
